// *** src/iwcc_pkg.sv ***
// shared constants and carriers for the i2c wiper code control block
package iwcc_pkg;
  localparam int CODE_W = 8;
  localparam logic [7:0] MIDSCALE = 8'h80;
  localparam logic [4:0] ADDR_HI = 5'h0b;
  localparam int INS_CHAN = 7;
  localparam int INS_MID = 6;
  localparam int INS_PD = 5;
  localparam int INS_O2 = 4;
  localparam int INS_O1 = 3;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // slave sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    IWCC_IDLE = 3'b000,
    IWCC_ADDR = 3'b001,
    IWCC_INS = 3'b011,
    IWCC_DATA = 3'b010,
    IWCC_READ = 3'b110,
    IWCC_IGN = 3'b100
  } iwcc_state_t;

  // one channel's analog switch controls
  typedef struct packed {
    logic top_open;
    logic wiper_to_bottom;
    logic [255:0] tap_sel;
  } iwcc_tap_t;
endpackage : iwcc_pkg

// *** src/iwcc_tap_decode.sv ***
// one channel's code-to-tap decoder with power-down override
`timescale 1ns/1ns
module iwcc_tap_decode #(
  parameter int TAPS = 256
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic [7:0] code,
  input wire logic pd,
  // ladder switches
  output iwcc_pkg::iwcc_tap_t tap
);
  typedef struct packed {
    iwcc_pkg::iwcc_tap_t tap;
  } iwcc_dec_st_t;
  iwcc_dec_st_t s_r, s_nxt;

  // one-hot decode, zero is bottom tap, each step one higher
  always_comb begin
    s_nxt = s_r;
    s_nxt.tap.tap_sel = '0;
    s_nxt.tap.top_open = pd;
    s_nxt.tap.wiper_to_bottom = pd;
    if (!pd) begin
      s_nxt.tap.tap_sel[code] = 1'b1;
    end
  end

  // registered so the switch drive is glitch free
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '{tap: '{top_open: 1'b0, wiper_to_bottom: 1'b0,
                      tap_sel: 256'h1 << 128}};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign tap = s_r.tap;

  property p_one_tap;
    @(posedge clock) disable iff (rst)
      !$past(pd) |-> $onehot(tap.tap_sel) && tap.tap_sel[$past(code)];
  endproperty
  a_one_tap: assert property (p_one_tap)
    else $error("tap not matching code");
  property p_pd_park;
    @(posedge clock) disable iff (rst)
      pd |=> tap.wiper_to_bottom && tap.top_open && tap.tap_sel == '0;
  endproperty
  a_pd_park: assert property (p_pd_park)
    else $error("power down not parking wiper");
endmodule : iwcc_tap_decode

// *** src/iwcc_top.sv ***
// i2c slave holding two wiper code latches with power down control
`timescale 1ns/1ns
module iwcc_top #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // two wire bus, sda open drain, oe low while driving low
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // straps and power down pin
  input wire logic addr_strap0,
  input wire logic addr_strap1,
  input wire logic power_down_pin_n,
  // latched logic outputs
  output logic logic_out1,
  output logic logic_out2,
  // ladder switch controls per channel
  output iwcc_pkg::iwcc_tap_t variable_resistor [CHANNELS],
  // visible codes
  output logic [7:0] wiper_code_latch [CHANNELS]
);
  // all state in one struct
  typedef struct packed {
    logic [1:0] scl_s1;
    logic [1:0] scl_s2;
    logic [1:0] sda_s1;
    logic [1:0] sda_s2;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic scl_d;
    logic sda_d;
    iwcc_pkg::iwcc_state_t st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] ins;
    logic oe_n; // registered copy of the pin enable, low while pulling
    logic drv_low;
    logic o1;
    logic o2;
    logic pd_bit;
    logic [15:0] codes;
  } iwcc_st_t;
  iwcc_st_t s_r, s_nxt;

  // synchronised views, second stage only
  logic scl, sda, pd_n, scl_rise, scl_fall, start_c, stop_c;
  logic [1:0] strap;
  logic [7:0] sel_code;
  assign scl = s_r.scl_s2[0];
  assign sda = s_r.sda_s2[0];
  assign strap = s_r.pin_s2[1:0];
  assign pd_n = s_r.pin_s2[2];
  assign scl_rise = scl && !s_r.scl_d;
  assign scl_fall = !scl && s_r.scl_d;
  assign start_c = scl && s_r.scl_d && s_r.sda_d && !sda;
  assign stop_c = scl && s_r.scl_d && !s_r.sda_d && sda;
  assign sel_code = s_r.ins[iwcc_pkg::INS_CHAN] ? s_r.codes[15:8]
                                                 : s_r.codes[7:0];

  // bus sequencer and latches
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s1 = {1'b0, scl_in};
    s_nxt.sda_s1 = {1'b0, sda_in};
    s_nxt.pin_s1 = {power_down_pin_n, addr_strap1, addr_strap0};
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.scl_d = scl;
    s_nxt.sda_d = sda;
    if (start_c) begin
      s_nxt.st = iwcc_pkg::IWCC_ADDR;
      s_nxt.bitn = '0;
      s_nxt.drv_low = 1'b0;
    end else if (stop_c) begin
      s_nxt.st = iwcc_pkg::IWCC_IDLE;
      s_nxt.drv_low = 1'b0;
    end else if (s_r.st != iwcc_pkg::IWCC_IDLE &&
                 s_r.st != iwcc_pkg::IWCC_IGN) begin
      if (scl_rise) begin
        // sample data bits on rising scl
        if (s_r.bitn <= iwcc_pkg::BIT_LAST) begin
          s_nxt.sh = {s_r.sh[6:0], sda};
          s_nxt.bitn = s_r.bitn + 4'h1;
        end else begin
          // ninth clock: master nack ends a read
          s_nxt.bitn = '0;
          if (s_r.st == iwcc_pkg::IWCC_READ && sda) begin
            s_nxt.st = iwcc_pkg::IWCC_IGN;
          end
        end
      end else if (scl_fall) begin
        s_nxt.drv_low = 1'b0;
        if (s_r.bitn == iwcc_pkg::BIT_ACK) begin
          // decode byte just shifted, decide ack
          case (s_r.st)
            iwcc_pkg::IWCC_ADDR: begin
              if (s_r.sh[7:3] == iwcc_pkg::ADDR_HI &&
                  s_r.sh[2:1] == {strap[1], strap[0]}) begin
                s_nxt.drv_low = 1'b1;
                s_nxt.st = s_r.sh[0] ? iwcc_pkg::IWCC_READ
                                     : iwcc_pkg::IWCC_INS;
              end else begin
                s_nxt.st = iwcc_pkg::IWCC_IGN;
              end
            end
            iwcc_pkg::IWCC_INS: begin
              s_nxt.ins = s_r.sh;
              s_nxt.o1 = s_r.sh[iwcc_pkg::INS_O1];
              s_nxt.o2 = s_r.sh[iwcc_pkg::INS_O2];
              s_nxt.pd_bit = s_r.sh[iwcc_pkg::INS_PD];
              s_nxt.drv_low = 1'b1;
              s_nxt.st = iwcc_pkg::IWCC_DATA;
            end
            iwcc_pkg::IWCC_DATA: begin
              // each data byte reapplies the stored instruction
              if (s_r.ins[iwcc_pkg::INS_CHAN] && CHANNELS > 1) begin
                s_nxt.codes[15:8] = s_r.ins[iwcc_pkg::INS_MID]
                  ? iwcc_pkg::MIDSCALE : s_r.sh;
              end else begin
                s_nxt.codes[7:0] = s_r.ins[iwcc_pkg::INS_MID]
                  ? iwcc_pkg::MIDSCALE : s_r.sh;
              end
              s_nxt.drv_low = 1'b1;
            end
            default: begin
              s_nxt.drv_low = 1'b0; // read: master acks
            end
          endcase
        end else if (s_r.st == iwcc_pkg::IWCC_READ) begin
          // read data msb first; only zeros are driven
          s_nxt.drv_low = !sel_code[3'(iwcc_pkg::BIT_LAST -
                                       s_r.bitn)];
        end
      end
    end
    // the read byte's first bit must be placed after the address ack
    if (scl_fall && s_r.st == iwcc_pkg::IWCC_READ &&
        s_r.bitn == '0 && s_r.drv_low && !start_c && !stop_c) begin
      s_nxt.drv_low = !sel_code[7];
    end
    // enable kept in its own flop so the pin has no gate after it
    s_nxt.oe_n = !s_nxt.drv_low;
  end

  // single register for all state; codes start at midscale
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '{scl_s1: 2'h1, scl_s2: 2'h1, sda_s1: 2'h1, sda_s2: 2'h1,
               pin_s1: 3'h4, pin_s2: 3'h4, scl_d: 1'b1, sda_d: 1'b1,
               st: iwcc_pkg::IWCC_IDLE, bitn: 4'h0, sh: 8'h00,
               ins: 8'h00, oe_n: 1'b1, drv_low: 1'b0, o1: 1'b0,
               o2: 1'b0, pd_bit: 1'b0,
               codes: {iwcc_pkg::MIDSCALE, iwcc_pkg::MIDSCALE}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // open drain: only ever pull low, scl never driven
  assign sda_out = 1'b0;
  assign sda_oe_n = s_r.oe_n;
  assign logic_out1 = s_r.o1;
  assign logic_out2 = s_r.o2;

  // per-channel ladder decode, pin or bit forces power down
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    assign wiper_code_latch[c] = s_r.codes[8*c +: 8];
    iwcc_tap_decode #(.TAPS(256)) u_dec (
      .clock(clock),
      .rst(rst),
      .code(s_r.codes[8*c +: 8]),
      .pd(!pd_n || s_r.pd_bit),
      .tap(variable_resistor[c])
    );
  end

  property p_pd_keeps;
    @(posedge clock) disable iff (rst)
      (!pd_n && !scl_fall) |=> $stable(s_r.codes);
  endproperty
  a_pd_keeps: assert property (p_pd_keeps)
    else $error("code changed without bus fall edge");
  property p_ack_match;
    @(posedge clock) disable iff (rst)
      (scl_fall && s_r.st == iwcc_pkg::IWCC_ADDR &&
       s_r.bitn == iwcc_pkg::BIT_ACK && !start_c && !stop_c)
      |=> s_r.drv_low == ($past(s_r.sh[7:3]) == iwcc_pkg::ADDR_HI &&
                           $past(s_r.sh[2:1]) == $past(strap));
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("address ack wrong");
  property p_start_addr;
    @(posedge clock) disable iff (rst)
      start_c |=> s_r.st == iwcc_pkg::IWCC_ADDR && s_r.bitn == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start not decoded");
  property p_stop_idle;
    @(posedge clock) disable iff (rst)
      stop_c && !start_c |=> s_r.st == iwcc_pkg::IWCC_IDLE && sda_oe_n;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop not released");
  property p_no_high;
    @(posedge clock) disable iff (rst) !sda_out;
  endproperty
  a_no_high: assert property (p_no_high)
    else $error("sda driven high");
  // the line may only be pulled while a transfer is under way
  property p_drive_scope;
    @(posedge clock) disable iff (rst)
      !sda_oe_n |-> s_r.st != iwcc_pkg::IWCC_IDLE &&
                    s_r.st != iwcc_pkg::IWCC_IGN;
  endproperty
  a_drive_scope: assert property (p_drive_scope)
    else $error("sda pulled outside a transfer");
  sequence s_data_ack;
    scl_fall && s_r.st == iwcc_pkg::IWCC_DATA &&
    s_r.bitn == iwcc_pkg::BIT_ACK && !start_c && !stop_c &&
    !s_r.ins[iwcc_pkg::INS_MID] && !s_r.ins[iwcc_pkg::INS_CHAN];
  endsequence
  property p_write_code;
    @(posedge clock) disable iff (rst)
      s_data_ack |=> s_r.codes[7:0] == $past(s_r.sh) ##1
      wiper_code_latch[0] == $past(s_r.sh, 2);
  endproperty
  a_write_code: assert property (p_write_code)
    else $error("data byte not stored");
  property p_ins_latch;
    @(posedge clock) disable iff (rst)
      (scl_fall && s_r.st == iwcc_pkg::IWCC_INS &&
       s_r.bitn == iwcc_pkg::BIT_ACK && !start_c && !stop_c)
      |=> ##1 logic_out1 == $past(s_r.sh[iwcc_pkg::INS_O1], 2);
  endproperty
  a_ins_latch: assert property (p_ins_latch)
    else $error("instruction outputs not latched");
  property p_read_nack;
    @(posedge clock) disable iff (rst)
      (scl_rise && s_r.st == iwcc_pkg::IWCC_READ &&
       s_r.bitn == iwcc_pkg::BIT_ACK && sda && !start_c && !stop_c)
      |=> s_r.st == iwcc_pkg::IWCC_IGN;
  endproperty
  a_read_nack: assert property (p_read_nack)
    else $error("read nack not honoured");
endmodule : iwcc_top

// *** tb/iwcc_master_model.sv ***
// behavioural bus master driving scl and its own side of sda
`timescale 1ns/1ns
module iwcc_master_model (
  // clock
  input wire logic clock,
  // device side of the open drain data line
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // resolved bus lines
  output logic scl,
  output logic sda
);
  logic sda_m; // master pull, 1 = released
  // wired and with pull-up, so a released line reads high
  assign sda = sda_m & (sda_oe_n | sda_out);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // half a 64 ns bus period
  task automatic half;
    repeat (4) @(posedge clock);
  endtask : half
  // start, also a repeated start from scl low
  task automatic start_c;
    @(posedge clock);
    sda_m <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b0;
    half();
    scl <= 1'b0;
  endtask : start_c
  // data moves one clock after scl falls, so it never races the fall
  task automatic bit_io(input logic b, output logic r);
    @(posedge clock);
    sda_m <= b;
    repeat (3) @(posedge clock);
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
  endtask : bit_io
  // msb first byte plus the ninth bit
  task automatic xfer(input logic [7:0] tx, input logic ack_m,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_m, ack);
  endtask : xfer
  // stop, data rises while scl high
  task automatic stop_c;
    @(posedge clock);
    sda_m <= 1'b0;
    repeat (3) @(posedge clock);
    scl <= 1'b1;
    half();
    sda_m <= 1'b1;
    half();
  endtask : stop_c
endmodule : iwcc_master_model

// *** tb/testbench.sv ***
// self-checking bench for the i2c wiper code control block
`timescale 1ns/1ns
module testbench;
  logic clock, rst, scl, sda, sda_out, sda_oe_n; // clock, reset, bus
  logic addr_strap0, addr_strap1, power_down_pin_n; // straps, pin
  logic logic_out1, logic_out2; // latched outputs
  iwcc_pkg::iwcc_tap_t variable_resistor [2]; // ladder switches
  logic [7:0] wiper_code_latch [2]; // stored codes
  int errors, checks_done;
  iwcc_top #(.CHANNELS(2)) u_dut (.clock(clock), .rst(rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_strap0(addr_strap0), .addr_strap1(addr_strap1),
    .power_down_pin_n(power_down_pin_n), .logic_out1(logic_out1),
    .logic_out2(logic_out2), .variable_resistor(variable_resistor),
    .wiper_code_latch(wiper_code_latch));
  iwcc_master_model u_master (.clock(clock), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  // 125 mhz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // compare and count, four-state exact
  task automatic check(input logic [257:0] seen, input logic [257:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  // let synchronisers and registered outputs land
  task automatic settle;
    repeat (6) @(posedge clock);
    #1;
  endtask : settle
  // our own address from the straps
  function automatic logic [6:0] me();
    return {iwcc_pkg::ADDR_HI, addr_strap1, addr_strap0};
  endfunction : me
  // expected switch state: one-hot tap, or parked when powered down
  task automatic chan(input int ch, input logic [7:0] c, input logic pd);
    iwcc_pkg::iwcc_tap_t t;
    t.top_open = pd;
    t.wiper_to_bottom = pd;
    t.tap_sel = pd ? 256'h0 : 256'h1 << c;
    check(258'(wiper_code_latch[ch]), 258'(c));
    check(variable_resistor[ch], t);
  endtask : chan
  // write: address, instruction, one or two data bytes
  task automatic wr(input logic [7:0] ins, d0, d1, input logic two);
    logic [7:0] rx;
    logic a;
    u_master.start_c();
    u_master.xfer({me(), 1'b0}, 1'b1, rx, a);
    check(258'(a), 258'(0));
    u_master.xfer(ins, 1'b1, rx, a);
    u_master.xfer(d0, 1'b1, rx, a);
    if (two) u_master.xfer(d1, 1'b1, rx, a);
    check(258'(a), 258'(0));
    u_master.stop_c();
    settle();
  endtask : wr
  // read: address, one data byte answered by no-acknowledge
  task automatic rd(input logic [6:0] ad, output logic [7:0] rx,
                    output logic a);
    logic n;
    u_master.start_c();
    u_master.xfer({ad, 1'b1}, 1'b1, rx, a);
    if (a === 1'b0) u_master.xfer(8'hff, 1'b1, rx, n);
    u_master.stop_c();
    settle();
  endtask : rd
  // power-up state
  task automatic t_reset;
    chan(0, iwcc_pkg::MIDSCALE, 1'b0);
    chan(1, iwcc_pkg::MIDSCALE, 1'b0);
    check(258'({logic_out2, logic_out1}), 258'(0));
    check(258'({sda_out, sda_oe_n}), 258'(1));
    $display("reset test done");
  endtask : t_reset
  // boundary codes on each channel, read back each one
  task automatic t_codes;
    logic [7:0] v [3] = '{8'h00, 8'h01, 8'hff};
    logic [7:0] rx;
    logic a;
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 3; i++) begin
        wr({ch[0], 7'h00}, v[i], 8'h00, 1'b0);
        chan(ch, v[i], 1'b0);
        rd(me(), rx, a);
        check(258'(rx), 258'(v[i]));
      end
      if (ch == 0) chan(1, iwcc_pkg::MIDSCALE, 1'b0);
    end
    $display("code test done");
  endtask : t_codes
  // wrong fixed bits, wrong strap, then a moved strap
  task automatic t_addr;
    logic [7:0] rx;
    logic a;
    rd({5'h0a, addr_strap1, addr_strap0}, rx, a);
    check(258'(a), 258'(1));
    check(258'(sda_oe_n), 258'(1));
    rd({iwcc_pkg::ADDR_HI, ~addr_strap1, addr_strap0}, rx, a);
    check(258'(a), 258'(1));
    @(posedge clock);
    addr_strap1 <= 1'b1;
    settle();
    rd(me(), rx, a);
    check(258'({a, rx}), 258'({1'b0, 8'hff}));
    $display("address test done");
  endtask : t_addr
  // repeated data under one instruction, outputs, midscale bit
  task automatic t_repeat;
    wr(8'h18, 8'h33, 8'h5a, 1'b1);
    chan(0, 8'h5a, 1'b0);
    check(258'({logic_out2, logic_out1}), 258'(3));
    wr(8'hc0, 8'h11, 8'h00, 1'b0);
    chan(1, iwcc_pkg::MIDSCALE, 1'b0);
    check(258'({logic_out2, logic_out1}), 258'(0));
    $display("repeat test done");
  endtask : t_repeat
  // power down by pin, then by instruction bit
  task automatic t_pd;
    @(posedge clock);
    power_down_pin_n <= 1'b0;
    settle();
    chan(0, 8'h5a, 1'b1);
    chan(1, iwcc_pkg::MIDSCALE, 1'b1);
    @(posedge clock);
    power_down_pin_n <= 1'b1;
    settle();
    chan(0, 8'h5a, 1'b0);
    wr(8'h20, 8'h40, 8'h00, 1'b0);
    chan(0, 8'h40, 1'b1);
    wr(8'h00, 8'h40, 8'h00, 1'b0);
    chan(0, 8'h40, 1'b0);
    $display("power down test done");
  endtask : t_pd
  // verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // hang guard
  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    conclude();
  end
  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    rst = 1'b1;
    addr_strap0 = 1'b1;
    addr_strap1 = 1'b0;
    power_down_pin_n = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    settle();
    t_reset();
    t_codes();
    t_addr();
    t_repeat();
    t_pd();
    conclude();
  end
endmodule : testbench
